// ### bench/rpms_host.sv
// Reset switch and debug host model on the reset and debug pins
`timescale 1ns/1ps
module rpms_host (
   // Clock
   input  wire logic       clk,
   // Device side of both pins
   input  wire logic       rst_oe,
   input  wire logic       rst_o,
   input  wire logic       dbg_oe,
   input  wire logic       dbg_o,
   // Bench commands
   input  wire logic       sw_low,
   input  wire logic       hold_low,
   input  wire logic       go,
   input  wire logic [7:0] low_len,
   // Pad levels
   output logic            rst_pin,
   output logic            dbg_pin
);
   logic [7:0] low_cnt;
   initial low_cnt = 8'h00;
   // Each host bit opens with a low pulse; its length gives the value
   always @(posedge clk) begin
      if (go) begin
         low_cnt <= low_len;
      end else if (low_cnt != 8'h00) begin
         low_cnt <= low_cnt - 8'h01;
      end
   end
   // Pull-ups on both pins; the host only ever pulls low
   assign rst_pin = (rst_oe ? rst_o : 1'b1) & ~sw_low;
   assign dbg_pin = (dbg_oe ? dbg_o : 1'b1)
                    & ~(hold_low | (low_cnt != 8'h00));
endmodule : rpms_host

// ### bench/testbench.sv
// Self-checking bench for the reset pin and mode select block
`timescale 1ns/1ps
module testbench;
   import rpms_pkg::*;
   logic       sys_clk, nrst, rst_pin, dbg_pin, sw_low, hold_low, go;
   logic       lvd, loc, ilad, ilop, cop, ext_sel, tx_req, tx_bit;
   logic       rst_oe, rst_o, dbg_oe, dbg_o, sys_reset_n, mode_bdm;
   logic       clk_int, tx_done, rx_bit, rx_valid;
   logic [7:0] cause, low_len;
   logic [3:0] div;
   int         mismatches, check_count, cycles;

   rpms_top u_dut (.SYS_CLK(sys_clk), .NRST(nrst), .LVD_REQ(lvd),
      .LOC_REQ(loc), .ILAD_REQ(ilad), .ILOP_REQ(ilop), .COP_REQ(cop),
      .RST_PIN_I(rst_pin), .RST_PIN_O(rst_o), .RST_PIN_OE(rst_oe),
      .DBG_PIN_I(dbg_pin), .DBG_PIN_O(dbg_o), .DBG_PIN_OE(dbg_oe),
      .SYS_RESET_N(sys_reset_n), .CAUSE(cause), .MODE_BDM(mode_bdm),
      .CLK_INTERNAL(clk_int), .CLK_EXT_SEL(ext_sel), .DBG_CLK_DIV(div),
      .DBG_TX_REQ(tx_req), .DBG_TX_BIT(tx_bit), .DBG_TX_DONE(tx_done),
      .DBG_RX_BIT(rx_bit), .DBG_RX_VALID(rx_valid));
   rpms_host u_host (.clk(sys_clk), .rst_oe(rst_oe), .rst_o(rst_o),
      .dbg_oe(dbg_oe), .dbg_o(dbg_o), .sw_low(sw_low),
      .hold_low(hold_low), .go(go), .low_len(low_len),
      .rst_pin(rst_pin), .dbg_pin(dbg_pin));

   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end

   task automatic chk(input string nm, input logic [7:0] e,
                      input logic [7:0] g);
      check_count++;
      if (g !== e) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   task automatic end_sim();
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : end_sim

   // A hang ends the run as a failure
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles >= 10000) begin
         mismatches++;
         end_sim();
      end
   end

   task automatic t_power_on();
      int n;
      int oe_n;
      nrst = 1'b0;
      repeat (12) @(negedge sys_clk);
      chk("por_cause", CAUSE_RST, cause);
      chk("por_oe", 8'h01, {7'h00, rst_oe});
      chk("por_clk", 8'h01, {7'h00, clk_int});
      chk("por_dbg_oe", 8'h00, {7'h00, dbg_oe});
      chk("por_pin", 8'h00, {7'h00, rst_pin});
      nrst = 1'b1;
      n = 0;
      oe_n = 0;
      while (sys_reset_n !== 1'b1 && n < 200) begin
         @(negedge sys_clk);
         n++;
         if (rst_oe === 1'b1) oe_n++;
      end
      // The reset state itself supplies the first drive cycle
      chk("por_release", 8'h01, {7'h00, sys_reset_n});
      chk("por_drive", 8'(RST_DRIVE_CYC - 1), 8'(oe_n));
      chk("por_mode", 8'h00, {7'h00, mode_bdm});
      $display("test power_on done");
   endtask : t_power_on

   // Applies a trigger and follows the whole reset sequence
   task automatic run_seq(input logic [4:0] req, input int sw_len,
                          input logic [7:0] exp_c, input logic exp_bdm);
      int n;
      int oe_n;
      logic in_rst;
      logic bad;
      n = 0;
      oe_n = 0;
      in_rst = 1'b0;
      bad = 1'b0;
      {lvd, loc, ilad, ilop, cop} = req;
      sw_low = (sw_len > 0);
      ext_sel = 1'b0;
      while (!(in_rst && sys_reset_n === 1'b1) && n < 400) begin
         @(negedge sys_clk);
         n++;
         {lvd, loc, ilad, ilop, cop} = 5'h00;
         if (n >= sw_len) sw_low = 1'b0;
         if (rst_oe === 1'b1) oe_n++;
         if (sys_reset_n === 1'b0) begin
            in_rst = 1'b1;
            if (dbg_oe !== 1'b0 || rx_valid !== 1'b0) bad = 1'b1;
         end
      end
      chk("release", 8'h01, {7'h00, sys_reset_n});
      chk("drive_len", 8'(RST_DRIVE_CYC), 8'(oe_n));
      chk("cause", exp_c, cause);
      chk("mode", {7'h00, exp_bdm}, {7'h00, mode_bdm});
      chk("clk_int", 8'h01, {7'h00, clk_int});
      chk("dbg_quiet", 8'h00, {7'h00, bad});
      chk("hold_pin", 8'h01, 8'(n > sw_len));
   endtask : run_seq

   task automatic t_internal();
      for (int i = 0; i < 5; i++) begin
         ext_sel = 1'b1;
         repeat (4) @(negedge sys_clk);
         chk("ext_clk", 8'h00, {7'h00, clk_int});
         run_seq(5'h10 >> i, 0, 8'h02 << i, 1'b0);
      end
      $display("test internal done");
   endtask : t_internal

   task automatic t_pin_reset();
      run_seq(5'h00, 3, 8'h40, 1'b0);
      run_seq(5'h00, 60, 8'h40, 1'b0);
      $display("test pin_reset done");
   endtask : t_pin_reset

   task automatic t_mode_bdm();
      hold_low = 1'b1;
      repeat (24) @(negedge sys_clk);
      run_seq(5'h01, 0, 8'h20, 1'b1);
      hold_low = 1'b0;
      repeat (4) @(negedge sys_clk);
      $display("test mode_bdm done");
   endtask : t_mode_bdm

   // Sources during the drive add to the cause; one in settle redrives
   task automatic t_stacked();
      int n;
      n = 0;
      lvd = 1'b1;
      @(negedge sys_clk);
      lvd = 1'b0;
      repeat (10) @(negedge sys_clk);
      cop = 1'b1;
      @(negedge sys_clk);
      cop = 1'b0;
      while (rst_oe !== 1'b0 && n < 60) begin
         @(negedge sys_clk);
         n++;
      end
      ilop = 1'b1;
      @(negedge sys_clk);
      ilop = 1'b0;
      chk("settle_redrive", 8'h01, {7'h00, rst_oe});
      repeat (30) @(negedge sys_clk);
      chk("redrive_hold", 8'h00, {7'h00, sys_reset_n});
      repeat (15) @(negedge sys_clk);
      chk("stack_cause", 8'h32, cause);
      chk("stack_release", 8'h01, {7'h00, sys_reset_n});
      $display("test stacked done");
   endtask : t_stacked

   task automatic dbg_rx(input logic b, input logic [3:0] d);
      int n;
      int k;
      k = int'(d) + 1;
      div = d;
      low_len = b ? 8'(3 * k) : 8'(14 * k);
      go = 1'b1;
      n = 0;
      @(negedge sys_clk);
      go = 1'b0;
      while (rx_valid !== 1'b1 && n < 40 * k) begin
         @(negedge sys_clk);
         n++;
      end
      chk("rx_bit", {7'h00, b}, {7'h00, rx_bit});
      chk("rx_time", 8'h01, 8'(n >= 8 * k && n <= 15 * k));
      repeat (8 * k) @(negedge sys_clk);
      $display("test dbg_rx done");
   endtask : dbg_rx

   task automatic dbg_tx(input logic b, input logic [3:0] d);
      int n;
      int k;
      logic lvl;
      logic spd;
      k = int'(d) + 1;
      div = d;
      tx_req = 1'b1;
      tx_bit = b;
      low_len = 8'(2 * k);
      go = 1'b1;
      n = 0;
      spd = 1'b0;
      lvl = 1'bx;
      @(negedge sys_clk);
      go = 1'b0;
      while (tx_done !== 1'b1 && n < 40 * k) begin
         @(negedge sys_clk);
         n++;
         if (n == 11 * k) lvl = dbg_pin;
         if (dbg_oe === 1'b1 && dbg_o === 1'b1) spd = 1'b1;
      end
      tx_req = 1'b0;
      chk("tx_level", {7'h00, b}, {7'h00, lvl});
      chk("tx_speedup", {7'h00, ~b}, {7'h00, spd});
      chk("tx_time", 8'h01, 8'(n >= 15 * k && n <= 18 * k));
      repeat (4 * k) @(negedge sys_clk);
      $display("test dbg_tx done");
   endtask : dbg_tx

   initial begin
      {nrst, sw_low, hold_low, go, ext_sel, tx_req, tx_bit} = 7'h00;
      {lvd, loc, ilad, ilop, cop} = 5'h00;
      low_len = 8'h00;
      div = DIV_RST;
      mismatches = 0;
      check_count = 0;
      cycles = 0;
      @(negedge sys_clk);
      t_power_on();
      dbg_rx(1'b0, 4'h0);
      dbg_rx(1'b1, 4'h0);
      dbg_rx(1'b0, 4'h1);
      dbg_tx(1'b0, 4'h0);
      dbg_tx(1'b1, 4'h0);
      dbg_tx(1'b0, 4'h1);
      t_internal();
      t_mode_bdm();
      t_pin_reset();
      t_stacked();
      end_sim();
   end
endmodule : testbench

// ### core/rpms_bit_if.sv
// Bit-level carrier between the reset sequencer and the debug bit engine
`timescale 1ns/1ps
interface rpms_bit_if;
   logic tick;
   logic en;
   logic tx_req;
   logic tx_bit;
   logic pin_in;
   logic pin_out;
   logic pin_oe;
   logic rx_bit;
   logic rx_valid;
   logic tx_done;

   modport eng (
      input  tick, en, tx_req, tx_bit, pin_in,
      output pin_out, pin_oe, rx_bit, rx_valid, tx_done
   );
   modport ctl (
      output tick, en, tx_req, tx_bit, pin_in,
      input  pin_out, pin_oe, rx_bit, rx_valid, tx_done
   );
endinterface : rpms_bit_if

// ### core/rpms_dbg_eng.sv
// Single-wire debug bit engine
`timescale 1ns/1ps
module rpms_dbg_eng (
   input wire logic clk,
   input wire logic nrst,
   rpms_bit_if.eng  bus
);
   import rpms_pkg::*;

   logic       prev_reg;
   logic       busy_reg;
   logic       txm_reg;
   logic [3:0] tcnt_reg;
   logic       start;
   logic       step;

   // Host opens every bit with a falling edge
   assign start = bus.en && !busy_reg && prev_reg && !bus.pin_in;
   // A bit cut by reset must not leave a late pulse inside reset
   assign step  = busy_reg && bus.tick && bus.en;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         prev_reg <= 1'b1;
         busy_reg <= 1'b0;
         txm_reg  <= 1'b0;
         tcnt_reg <= 4'h0;
      end else begin
         prev_reg <= bus.pin_in;
         if (!bus.en) begin
            busy_reg <= 1'b0;
            tcnt_reg <= 4'h0;
         end else if (start) begin
            busy_reg <= 1'b1;
            tcnt_reg <= 4'h0;
            txm_reg  <= bus.tx_req;
         end else if (step) begin
            tcnt_reg <= tcnt_reg + 4'h1;
            if (tcnt_reg == BIT_LAST) begin
               busy_reg <= 1'b0;
            end
         end
      end
   end

   // Pin is never driven high except as a short speedup after a low
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         bus.pin_oe  <= 1'b0;
         bus.pin_out <= 1'b0;
      end else if (!bus.en) begin
         bus.pin_oe  <= 1'b0;
         bus.pin_out <= 1'b0;
      end else if (start && bus.tx_req && !bus.tx_bit) begin
         bus.pin_oe  <= 1'b1;
         bus.pin_out <= 1'b0;
      end else if (step && tcnt_reg == SPEEDUP_AT && bus.pin_oe) begin
         bus.pin_out <= 1'b1;
      end else if (step && tcnt_reg == RELEASE_AT) begin
         bus.pin_oe  <= 1'b0;
         bus.pin_out <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         bus.rx_bit   <= 1'b0;
         bus.rx_valid <= 1'b0;
         bus.tx_done  <= 1'b0;
      end else begin
         bus.rx_valid <= step && !txm_reg && tcnt_reg == RX_SAMPLE_AT;
         bus.tx_done  <= step && txm_reg && tcnt_reg == BIT_LAST;
         if (step && !txm_reg && tcnt_reg == RX_SAMPLE_AT) begin
            bus.rx_bit <= bus.pin_in;
         end
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   property p_bit_len;
      $fell(busy_reg) |-> ($past(tcnt_reg) == BIT_LAST || !$past(bus.en));
   endproperty
   a_bit_len: assert property (p_bit_len)
      else $error("debug bit ended before sixteen ticks");

   property p_speedup;
      $rose(bus.pin_oe && bus.pin_out) |-> $past(bus.pin_oe && !bus.pin_out);
   endproperty
   a_speedup: assert property (p_speedup)
      else $error("high drive not preceded by low drive");

   c_tx_done: cover property (bus.tx_done);
   c_rx_bit: cover property (bus.rx_valid && !bus.rx_bit);
endmodule : rpms_dbg_eng

// ### core/rpms_pkg.sv
// Constants and types for the reset pin and mode select block
package rpms_pkg;
   localparam int          RST_DRIVE_CYC  = 34;
   localparam logic [5:0]  RST_DRIVE_LAST = 6'(RST_DRIVE_CYC - 1);
   localparam int          BIT_TICKS      = 16;
   localparam logic [3:0]  BIT_LAST       = 4'(BIT_TICKS - 1);
   localparam logic [3:0]  RX_SAMPLE_AT   = 4'hA;
   localparam logic [3:0]  SPEEDUP_AT     = 4'hC;
   localparam logic [3:0]  RELEASE_AT     = 4'hD;
   localparam int          CAUSE_W        = 8;
   localparam int          CAUSE_LVD      = 1;
   localparam int          CAUSE_LOC      = 2;
   localparam int          CAUSE_ILAD     = 3;
   localparam int          CAUSE_ILOP     = 4;
   localparam int          CAUSE_COP      = 5;
   localparam int          CAUSE_PIN      = 6;
   localparam int          CAUSE_POR      = 7;
   localparam logic [7:0]  CAUSE_RST      = 8'h80;
   localparam logic [3:0]  DIV_RST        = 4'h0;

   typedef enum logic [1:0] {
      RPMS_DRIVE  = 2'b00,
      RPMS_SETTLE = 2'b01,
      RPMS_RUN    = 2'b11
   } rpms_state_t;
endpackage : rpms_pkg

// ### core/rpms_sync.sv
// Two-stage synchroniser for the reset pin
`timescale 1ns/1ps
module rpms_sync (
   input  wire logic clk,
   input  wire logic nrst,
   input  wire logic d,
   output logic      q
);
   logic meta_reg;

   // Idle level of the pin is high, so both stages reset high
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         meta_reg <= 1'b1;
         q        <= 1'b1;
      end else begin
         meta_reg <= d;
         q        <= meta_reg;
      end
   end
endmodule : rpms_sync

// ### core/rpms_top.sv
// Reset pin driver, reset cause capture, mode select and debug pin
`timescale 1ns/1ps
module rpms_top (
   // Clock and power-on reset
   input  wire logic                      SYS_CLK,
   input  wire logic                      NRST,
   // Internal reset sources
   input  wire logic                      LVD_REQ,
   input  wire logic                      LOC_REQ,
   input  wire logic                      ILAD_REQ,
   input  wire logic                      ILOP_REQ,
   input  wire logic                      COP_REQ,
   // Reset pin
   input  wire logic                      RST_PIN_I,
   output logic                           RST_PIN_O,
   output logic                           RST_PIN_OE,
   // Debug and mode select pin
   input  wire logic                      DBG_PIN_I,
   output logic                           DBG_PIN_O,
   output logic                           DBG_PIN_OE,
   // System status
   output logic                           SYS_RESET_N,
   output logic [rpms_pkg::CAUSE_W-1:0]   CAUSE,
   output logic                           MODE_BDM,
   output logic                           CLK_INTERNAL,
   input  wire logic                      CLK_EXT_SEL,
   // Debug link user side
   input  wire logic [3:0]                DBG_CLK_DIV,
   input  wire logic                      DBG_TX_REQ,
   input  wire logic                      DBG_TX_BIT,
   output logic                           DBG_TX_DONE,
   output logic                           DBG_RX_BIT,
   output logic                           DBG_RX_VALID
);
   import rpms_pkg::*;

   rpms_state_t        state_reg;
   rpms_state_t        state_next;
   logic [5:0]         cnt_reg;
   logic               rst_pin_s;
   logic               rst_oe_reg;
   logic               sysrst_reg;
   logic [CAUSE_W-1:0] cause_reg;
   logic [CAUSE_W-1:0] int_vec;
   logic [CAUSE_W-1:0] req_vec;
   logic               int_req;
   logic               pin_req;
   logic               mode_reg;
   logic               clk_int_reg;
   logic [3:0]         div_cnt_reg;
   logic               tick_reg;

   rpms_bit_if bus ();

   // Pin is asynchronous to the bus clock
   rpms_sync u_sync (
      .clk  (SYS_CLK),
      .nrst (NRST),
      .d    (RST_PIN_I),
      .q    (rst_pin_s)
   );

   always_comb begin
      int_vec             = '0;
      int_vec[CAUSE_LVD]  = LVD_REQ;
      int_vec[CAUSE_LOC]  = LOC_REQ;
      int_vec[CAUSE_ILAD] = ILAD_REQ;
      int_vec[CAUSE_ILOP] = ILOP_REQ;
      int_vec[CAUSE_COP]  = COP_REQ;
   end

   // Our own low drive shows on the pin, so the pin only counts in run
   assign pin_req = (state_reg == RPMS_RUN) && !rst_pin_s;
   assign int_req = |int_vec;

   always_comb begin
      req_vec            = int_vec;
      req_vec[CAUSE_PIN] = pin_req;
   end

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         RPMS_RUN: begin
            if (int_req || pin_req) begin
               state_next = RPMS_DRIVE;
            end
         end
         RPMS_DRIVE: begin
            if (cnt_reg == RST_DRIVE_LAST) begin
               state_next = RPMS_SETTLE;
            end
         end
         RPMS_SETTLE: begin
            if (int_req) begin
               state_next = RPMS_DRIVE;
            end else if (rst_pin_s) begin
               state_next = RPMS_RUN;
            end
         end
         default: begin
            state_next = RPMS_DRIVE;
         end
      endcase
   end

   always_ff @(posedge SYS_CLK or negedge NRST) begin
      if (!NRST) begin
         state_reg <= RPMS_DRIVE;
      end else begin
         state_reg <= state_next;
      end
   end

   always_ff @(posedge SYS_CLK or negedge NRST) begin
      if (!NRST) begin
         cnt_reg <= 6'h00;
      end else if (state_next != RPMS_DRIVE || state_reg != RPMS_DRIVE) begin
         cnt_reg <= 6'h00;
      end else begin
         cnt_reg <= cnt_reg + 6'h01;
      end
   end

   // Power-on reset also counts as a reset start
   always_ff @(posedge SYS_CLK or negedge NRST) begin
      if (!NRST) begin
         rst_oe_reg <= 1'b1;
      end else begin
         rst_oe_reg <= (state_next == RPMS_DRIVE);
      end
   end

   always_ff @(posedge SYS_CLK or negedge NRST) begin
      if (!NRST) begin
         sysrst_reg <= 1'b0;
      end else begin
         sysrst_reg <= (state_next == RPMS_RUN);
      end
   end

   // A new reset replaces the old cause; sources during reset add to it
   always_ff @(posedge SYS_CLK or negedge NRST) begin
      if (!NRST) begin
         cause_reg <= CAUSE_RST;
      end else if (state_reg == RPMS_RUN && state_next == RPMS_DRIVE) begin
         cause_reg <= req_vec;
      end else if (state_reg != RPMS_RUN) begin
         cause_reg <= cause_reg | int_vec;
      end
   end

   // Strap caught by the clock edge at reset release
   always_ff @(posedge SYS_CLK or negedge NRST) begin
      if (!NRST) begin
         mode_reg <= 1'b0;
      end else if (state_reg != RPMS_RUN && state_next == RPMS_RUN) begin
         mode_reg <= !DBG_PIN_I;
      end
   end

   // Software may move to the crystal only once running
   always_ff @(posedge SYS_CLK or negedge NRST) begin
      if (!NRST) begin
         clk_int_reg <= 1'b1;
      end else if (state_next != RPMS_RUN) begin
         clk_int_reg <= 1'b1;
      end else if (CLK_EXT_SEL) begin
         clk_int_reg <= 1'b0;
      end
   end

   // Debug clock enable; a divide of zero gives bus rate
   always_ff @(posedge SYS_CLK or negedge NRST) begin
      if (!NRST) begin
         div_cnt_reg <= DIV_RST;
         tick_reg    <= 1'b0;
      end else if (!sysrst_reg) begin
         div_cnt_reg <= DIV_RST;
         tick_reg    <= 1'b0;
      end else if (div_cnt_reg >= DBG_CLK_DIV) begin
         div_cnt_reg <= DIV_RST;
         tick_reg    <= 1'b1;
      end else begin
         div_cnt_reg <= div_cnt_reg + 4'h1;
         tick_reg    <= 1'b0;
      end
   end

   // Engine held idle in reset so the pin is a pure mode input there
   assign bus.en     = sysrst_reg;
   assign bus.tick   = tick_reg;
   assign bus.tx_req = DBG_TX_REQ;
   assign bus.tx_bit = DBG_TX_BIT;
   assign bus.pin_in = DBG_PIN_I;

   rpms_dbg_eng u_eng (
      .clk  (SYS_CLK),
      .nrst (NRST),
      .bus  (bus.eng)
   );

   // Open drain: the reset pin output level is always low
   assign RST_PIN_O    = 1'b0;
   assign RST_PIN_OE   = rst_oe_reg;
   assign DBG_PIN_O    = bus.pin_out;
   assign DBG_PIN_OE   = bus.pin_oe;
   assign SYS_RESET_N  = sysrst_reg;
   assign CAUSE        = cause_reg;
   assign MODE_BDM     = mode_reg;
   assign CLK_INTERNAL = clk_int_reg;
   assign DBG_TX_DONE  = bus.tx_done;
   assign DBG_RX_BIT   = bus.rx_bit;
   assign DBG_RX_VALID = bus.rx_valid;

   // Sequencer checks; the engine checks its own bit timing
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (!NRST);

   property p_drive_len;
      $rose(RST_PIN_OE) |-> ##33 RST_PIN_OE ##1 !RST_PIN_OE;
   endproperty
   a_drive_len: assert property (p_drive_len)
      else $error("reset pin low drive not 34 cycles");

   property p_cause_cop;
      (state_reg == RPMS_RUN && COP_REQ)
         |=> (CAUSE[CAUSE_COP] && !SYS_RESET_N && RST_PIN_OE);
   endproperty
   a_cause_cop: assert property (p_cause_cop)
      else $error("watchdog reset not recorded");

   property p_pin_reset;
      (state_reg == RPMS_RUN && !rst_pin_s)
         |=> (RST_PIN_OE && CAUSE[CAUSE_PIN] && !SYS_RESET_N);
   endproperty
   a_pin_reset: assert property (p_pin_reset)
      else $error("external pin reset not taken");

   property p_release;
      $rose(SYS_RESET_N) |-> $past(!RST_PIN_OE && rst_pin_s);
   endproperty
   a_release: assert property (p_release)
      else $error("reset released while pin low or driven");

   property p_mode;
      $rose(SYS_RESET_N) |-> (MODE_BDM == !$past(DBG_PIN_I));
   endproperty
   a_mode: assert property (p_mode)
      else $error("mode select strap captured wrongly");

   property p_pin_quiet;
      (!SYS_RESET_N && !$past(SYS_RESET_N)) |-> !DBG_PIN_OE;
   endproperty
   a_pin_quiet: assert property (p_pin_quiet)
      else $error("debug pin driven during reset");

   property p_clk_int;
      !SYS_RESET_N |-> CLK_INTERNAL;
   endproperty
   a_clk_int: assert property (p_clk_int)
      else $error("external clock selected in reset");

   property p_bus_rate;
      (SYS_RESET_N && $past(SYS_RESET_N) && DBG_CLK_DIV == 4'h0
         && $past(DBG_CLK_DIV) == 4'h0) |-> tick_reg;
   endproperty
   a_bus_rate: assert property (p_bus_rate)
      else $error("debug clock not at bus rate");

   property p_settle_redrive;
      (state_reg == RPMS_SETTLE && int_req)
         |=> (RST_PIN_OE && !SYS_RESET_N);
   endproperty
   a_settle_redrive: assert property (p_settle_redrive)
      else $error("request in settle did not restart the drive");

   property p_cause_add;
      (state_reg != RPMS_RUN && COP_REQ) |=> CAUSE[CAUSE_COP];
   endproperty
   a_cause_add: assert property (p_cause_add)
      else $error("source during reset not added to cause");

   property p_settle_wait;
      (state_reg == RPMS_SETTLE && !rst_pin_s) |=> !SYS_RESET_N;
   endproperty
   a_settle_wait: assert property (p_settle_wait)
      else $error("reset released while pin still low");

   property p_mode_hold;
      (SYS_RESET_N && $past(SYS_RESET_N)) |-> $stable(MODE_BDM);
   endproperty
   a_mode_hold: assert property (p_mode_hold)
      else $error("mode changed while running");

   property p_tick_rst;
      (!SYS_RESET_N && !$past(SYS_RESET_N)) |-> !tick_reg;
   endproperty
   a_tick_rst: assert property (p_tick_rst)
      else $error("debug clock ticking during reset");

   c_pin_reset: cover property (state_reg == RPMS_RUN && !rst_pin_s);
   c_bdm_entry: cover property ($rose(SYS_RESET_N) && MODE_BDM);
   c_cop_reset: cover property (state_reg == RPMS_RUN && COP_REQ);
endmodule : rpms_top
